// *** src/ipc_pkg.sv ***
// ipc_pkg: shared constants for the inrush peak capture block
// assumes: one 100 MHz clock, signed current samples from the front end
package ipc_pkg;
    localparam int          SMP_W      = 16;
    localparam int          RANGE_W    = 3;
    localparam logic [2:0]  RANGE_TOP  = 3'h4;     // highest current range (400 A peak)
    localparam logic [2:0]  RANGE_LOW  = 3'h0;
    localparam int          CYC_W      = 16;
    localparam logic [15:0] CYC_MIN    = 16'h0004; // shortest on/off time in supply cycles
    localparam logic [15:0] CYC_MAX    = 16'hFFFF;
    localparam int          PH_IN_W    = 11;       // entered phase, -999..999 degrees
    localparam int          PH_W       = 9;
    localparam logic [11:0] DEG_FULL   = 12'h168;  // 360 degrees
    localparam logic [11:0] DEG_BIAS   = 12'h438;  // 3 * 360, lifts -999 above zero
    localparam int          WRAP_STEPS = 6;
    typedef enum logic [4:0] {
        SEQ_IDLE     = 5'b00001,
        SEQ_WAIT_ON  = 5'b00010,
        SEQ_ON       = 5'b00100,
        SEQ_WAIT_OFF = 5'b01000,
        SEQ_OFF      = 5'b10000
    } ipc_seq_t;
endpackage

// *** src/ipc_peak_hold.sv ***
// ipc_peak_hold: one peak-hold set, positive and negative extremes
// assumes: samples and controls on clk_i; clear beats load and sample; a sample in a load cycle is merged into the loaded values
`timescale 1ns/1ps
module ipc_peak_hold
    import ipc_pkg::*;
#(
    parameter int W = SMP_W
) (
    input  wire logic                clk_i,
    input  wire logic                rst_n_i,
    input  wire logic                clr_i,
    input  wire logic                load_i,
    input  wire logic signed [W-1:0] ld_pos_i,
    input  wire logic signed [W-1:0] ld_neg_i,
    input  wire logic                smp_valid_i,
    input  wire logic signed [W-1:0] smp_i,
    output logic signed [W-1:0]      pos_o,
    output logic signed [W-1:0]      neg_o
);
    typedef struct packed {
        logic signed [W-1:0] pos;
        logic signed [W-1:0] neg;
    } ipc_hold_t;

    ipc_hold_t s;
    ipc_hold_t next_s;

    // ----------------------------------------
    // update
    // ----------------------------------------
    always_comb begin
        next_s = s;
        if (load_i) begin
            next_s.pos = ld_pos_i;
            next_s.neg = ld_neg_i;
        end
        if (smp_valid_i && smp_i > next_s.pos) begin
            next_s.pos = smp_i;
        end
        if (smp_valid_i && smp_i < next_s.neg) begin
            next_s.neg = smp_i;
        end
        if (clr_i) begin
            next_s = '0;
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    assign pos_o = s.pos;
    assign neg_o = s.neg;

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);

    a_start_clear: assert property (clr_i |=> pos_o == '0 && neg_o == '0)
        else $error("peak set not cleared by start");
    a_pos_mono: assert property (!clr_i && !load_i |=> pos_o >= $past(pos_o) && neg_o <= $past(neg_o))
        else $error("held extreme fell without clear or load");
    a_sample_taken: assert property (!clr_i && !load_i && smp_valid_i && smp_i > pos_o |=> pos_o == $past(smp_i))
        else $error("larger sample not stored");
endmodule // ipc_peak_hold

// *** src/ipc_inrush_capture.sv ***
// ipc_inrush_capture: peak inrush capture, event detector, range control, relay sequencer
// assumes: front end gives samples, half and cycle ticks and supply phase on clk_i
`timescale 1ns/1ps
module ipc_inrush_capture
    import ipc_pkg::*;
#(
    parameter int W = SMP_W
) (
    input  wire logic                    clk_i,
    input  wire logic                    rst_n_i,
    input  wire logic                    mode_inrush_i,
    input  wire logic                    start_i,
    input  wire logic                    smp_valid_i,
    input  wire logic signed [W-1:0]     smp_i,
    input  wire logic                    half_tick_i,
    input  wire logic                    cycle_tick_i,
    input  wire logic [PH_W-1:0]         phase_deg_i,
    input  wire logic                    trig_src_inrush_i,
    input  wire logic                    range_up_i,
    input  wire logic                    range_down_i,
    input  wire logic                    seq_enable_i,
    input  wire logic                    seq_cfg_we_i,
    input  wire logic [CYC_W-1:0]        on_cycles_i,
    input  wire logic [CYC_W-1:0]        off_cycles_i,
    input  wire logic signed [PH_IN_W-1:0] on_phase_i,
    input  wire logic signed [PH_IN_W-1:0] off_phase_i,
    output logic signed [W-1:0]          latest_pos_o,
    output logic signed [W-1:0]          latest_neg_o,
    output logic signed [W-1:0]          highest_pos_o,
    output logic signed [W-1:0]          highest_neg_o,
    output logic                         event_o,
    output logic                         trig_o,
    output logic [RANGE_W-1:0]           range_o,
    output logic                         autorange_en_o,
    output logic                         disp_inrush_o,
    output logic                         relay_on_o,
    output logic                         seq_err_o,
    output logic [PH_W-1:0]              on_phase_o,
    output logic [PH_W-1:0]              off_phase_o
);
    typedef struct packed {
        logic [W-1:0]        hp;      // half-cycle magnitude peak
        logic [W-1:0]        cp;      // cycle magnitude peak
        logic [W-1:0]        prev_cp;
        logic signed [W-1:0] hc_pos;
        logic signed [W-1:0] hc_neg;
        logic signed [W-1:0] ev_pos;  // extremes of the last finished half cycle
        logic signed [W-1:0] ev_neg;
        logic                mode_d;
        logic [RANGE_W-1:0]  range;
        logic                event_p;
        logic                trig_p;
        logic [CYC_W-1:0]    on_cyc;
        logic [CYC_W-1:0]    off_cyc;
        logic [PH_W-1:0]     on_ph;
        logic [PH_W-1:0]     off_ph;
        logic                seq_err;
        ipc_seq_t            st;
        logic [CYC_W-1:0]    cnt;
        logic                relay;
    } ipc_state_t;

    ipc_state_t s;
    ipc_state_t next_s;

    // ----------------------------------------
    // helpers
    // ----------------------------------------
    function automatic logic [PH_W-1:0] wrap_deg(input logic signed [PH_IN_W-1:0] v);
        logic [11:0] t;
        t = 12'(DEG_BIAS + 12'(signed'(v)));
        for (int i = 0; i < WRAP_STEPS; i++) begin
            if (t >= DEG_FULL) begin
                t = t - DEG_FULL;
            end
        end
        return t[PH_W-1:0];
    endfunction

    logic [W:0]   abs_wide;
    logic [W-1:0] mag;
    logic         smp_ok;
    logic         ev;
    logic         ld_event;

    assign abs_wide = smp_i[W-1] ? (W+1)'(-signed'({smp_i[W-1], smp_i})) : {1'b0, smp_i};
    assign mag      = abs_wide[W-1:0];
    assign smp_ok   = smp_valid_i && mode_inrush_i;
    // hazard: the doubled reference needs one extra bit or large peaks wrap
    assign ev       = mode_inrush_i && half_tick_i && ({1'b0, s.hp} > {s.prev_cp, 1'b0});
    assign ld_event = s.event_p;

    // ----------------------------------------
    // next state
    // ----------------------------------------
    always_comb begin
        next_s         = s;
        next_s.event_p = ev;
        next_s.trig_p  = ev && trig_src_inrush_i;
        next_s.mode_d  = mode_inrush_i;
        if (half_tick_i) begin
            // kept apart: the running half extremes restart in this same cycle
            next_s.ev_pos = s.hc_pos;
            next_s.ev_neg = s.hc_neg;
            next_s.hp     = '0;
            next_s.hc_pos = '0;
            next_s.hc_neg = '0;
        end
        if (cycle_tick_i) begin
            next_s.prev_cp = s.cp;
            next_s.cp      = '0;
        end
        if (smp_ok) begin
            if (mag > next_s.hp) next_s.hp = mag;
            if (mag > next_s.cp) next_s.cp = mag;
            if (smp_i > next_s.hc_pos) next_s.hc_pos = smp_i;
            if (smp_i < next_s.hc_neg) next_s.hc_neg = smp_i;
        end
        if (mode_inrush_i && !s.mode_d) begin
            next_s.range = RANGE_TOP;
        end else if (mode_inrush_i && range_up_i && s.range != RANGE_TOP) begin
            next_s.range = s.range + 3'h1;
        end else if (mode_inrush_i && range_down_i && s.range != RANGE_LOW) begin
            next_s.range = s.range - 3'h1;
        end
        if (seq_cfg_we_i) begin
            next_s.on_ph  = wrap_deg(on_phase_i);
            next_s.off_ph = wrap_deg(off_phase_i);
            if (on_cycles_i >= CYC_MIN && on_cycles_i <= CYC_MAX &&
                off_cycles_i >= CYC_MIN && off_cycles_i <= CYC_MAX) begin
                next_s.on_cyc  = on_cycles_i;
                next_s.off_cyc = off_cycles_i;
                next_s.seq_err = 1'b0;
            end else begin
                next_s.seq_err = 1'b1;
            end
        end
        // relay sequencer; switching waits for the programmed phase, except that seq_enable_i low forces the relay off at once
        unique case (s.st)
            SEQ_IDLE: begin
                next_s.relay = 1'b0;
                if (seq_enable_i) next_s.st = SEQ_WAIT_ON;
            end
            SEQ_WAIT_ON: begin
                if (phase_deg_i == s.on_ph) begin
                    next_s.st    = SEQ_ON;
                    next_s.relay = 1'b1;
                    next_s.cnt   = s.on_cyc;
                end
            end
            SEQ_ON: begin
                if (cycle_tick_i) begin
                    next_s.cnt = s.cnt - 16'h0001;
                    if (s.cnt <= 16'h0001) next_s.st = SEQ_WAIT_OFF;
                end
            end
            SEQ_WAIT_OFF: begin
                if (phase_deg_i == s.off_ph) begin
                    next_s.st    = SEQ_OFF;
                    next_s.relay = 1'b0;
                    next_s.cnt   = s.off_cyc;
                end
            end
            SEQ_OFF: begin
                if (cycle_tick_i) begin
                    next_s.cnt = s.cnt - 16'h0001;
                    if (s.cnt <= 16'h0001) next_s.st = SEQ_WAIT_ON;
                end
            end
            default: begin
                next_s.st    = SEQ_IDLE;
                next_s.relay = 1'b0;
            end
        endcase
        if (!seq_enable_i) begin
            next_s.st    = SEQ_IDLE;
            next_s.relay = 1'b0;
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            s         <= '0;
            s.range   <= RANGE_TOP;
            s.on_cyc  <= CYC_MIN;
            s.off_cyc <= CYC_MIN;
            s.st      <= SEQ_IDLE;
        end else begin
            s <= next_s;
        end
    end

    // ----------------------------------------
    // peak-hold sets
    // ----------------------------------------
    // newest event: reloaded with the finished half-cycle extremes
    ipc_peak_hold #(.W(W)) u_latest (
        .clk_i      (clk_i),
        .rst_n_i    (rst_n_i),
        .clr_i      (start_i),
        .load_i     (ld_event),
        .ld_pos_i   (s.ev_pos),
        .ld_neg_i   (s.ev_neg),
        .smp_valid_i(smp_ok),
        .smp_i      (smp_i),
        .pos_o      (latest_pos_o),
        .neg_o      (latest_neg_o)
    );

    // overall maximum: never reloaded, so events leave it alone
    ipc_peak_hold #(.W(W)) u_highest (
        .clk_i      (clk_i),
        .rst_n_i    (rst_n_i),
        .clr_i      (start_i),
        .load_i     (1'b0),
        .ld_pos_i   ('0),
        .ld_neg_i   ('0),
        .smp_valid_i(smp_ok),
        .smp_i      (smp_i),
        .pos_o      (highest_pos_o),
        .neg_o      (highest_neg_o)
    );

    assign event_o        = s.event_p;
    assign trig_o         = s.trig_p;
    assign range_o        = s.range;
    assign autorange_en_o = !mode_inrush_i;
    assign disp_inrush_o  = mode_inrush_i;
    assign relay_on_o     = s.relay;
    assign seq_err_o      = s.seq_err;
    assign on_phase_o     = s.on_ph;
    assign off_phase_o    = s.off_ph;

    // ----------------------------------------
    // checks
    // ----------------------------------------
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);

    sequence s_on_done;
        s.st == SEQ_ON && cycle_tick_i && s.cnt == 16'h0001;
    endsequence

    a_event_cause: assert property (half_tick_i && mode_inrush_i && ({1'b0, s.hp} > {s.prev_cp, 1'b0}) |=> event_o)
        else $error("switching event missed");
    a_event_trig: assert property (event_o |-> trig_o == $past(trig_src_inrush_i))
        else $error("trigger does not follow event");
    a_cycle_peak: assert property (cycle_tick_i |=> s.prev_cp == $past(s.cp))
        else $error("cycle peak not registered");
    a_range_entry: assert property ($rose(mode_inrush_i) |=> range_o == RANGE_TOP)
        else $error("top range not selected on entry");
    a_autorange_off: assert property (mode_inrush_i |-> !autorange_en_o)
        else $error("autorange on in inrush mode");
    a_latest_reload: assert property (event_o && !start_i && smp_i == '0 |=>
        latest_pos_o == $past(s.ev_pos) && latest_neg_o == $past(s.ev_neg))
        else $error("newest set not reloaded on event");
    a_highest_kept: assert property (event_o && !start_i |=> highest_pos_o >= $past(highest_pos_o))
        else $error("overall maximum dropped on event");
    a_cfg_reject: assert property (seq_cfg_we_i && on_cycles_i < CYC_MIN |=> seq_err_o && s.on_cyc == $past(s.on_cyc))
        else $error("bad on time accepted");
    a_phase_range: assert property (on_phase_o < PH_W'(DEG_FULL) && off_phase_o < PH_W'(DEG_FULL))
        else $error("phase outside 0..359");
    a_relay_off: assert property (s_on_done ##1 seq_enable_i[*1] |-> relay_on_o)
        else $error("relay dropped before off phase");
endmodule // ipc_inrush_capture

// *** tb/ipc_front_end.sv ***
// ipc_front_end: supply phase, tick and load current model
// assumes: one sample per clock, 360 clocks per supply cycle
`timescale 1ns/1ps
module ipc_front_end
    import ipc_pkg::*;
(
    input  wire logic               clk_i,
    input  wire logic               relay_on_i,
    input  wire logic               manual_on_i,
    input  wire logic signed [15:0] amp_pos_i,
    input  wire logic signed [15:0] amp_neg_i,
    output logic                    smp_valid_o,
    output logic signed [15:0]      smp_o,
    output logic                    half_tick_o,
    output logic                    cycle_tick_o,
    output logic [PH_W-1:0]         phase_o
);
    logic loaded;
    initial phase_o = 9'h000;
    // ----------------------------------------
    // supply phase, one degree per clock
    // ----------------------------------------
    always @(negedge clk_i) begin
        phase_o <= (phase_o == 9'h167) ? 9'h000 : phase_o + 9'h001;
    end
    // half tick doubles as cycle tick at the rising crossing
    assign half_tick_o  = (phase_o == 9'h0B3) || (phase_o == 9'h167);
    assign cycle_tick_o = (phase_o == 9'h167);
    assign smp_valid_o  = 1'b1;
    // no current flows with the load switched off
    assign loaded = relay_on_i || manual_on_i;
    assign smp_o  = !loaded ? 16'sh0000 : (phase_o == 9'h05A) ? amp_pos_i :
                    (phase_o == 9'h05B) ? amp_neg_i : 16'sh0000;
endmodule // ipc_front_end

// *** tb/ipc_inrush_capture_tb.sv ***
// ipc_inrush_capture_tb: self-checking bench for the inrush capture block
// assumes: front end model supplies samples, ticks and phase
`timescale 1ns/1ps
module ipc_inrush_capture_tb;
    import ipc_pkg::*;
    logic clk_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic mode_i = 1'b0, start_i = 1'b0, trig_src_i = 1'b0;
    logic up_i = 1'b0, down_i = 1'b0, seq_en_i = 1'b0, cfg_we_i = 1'b0;
    logic manual_i = 1'b0;
    logic [15:0] on_cyc_i = 16'h0004, off_cyc_i = 16'h0004;
    logic signed [10:0] on_ph_i = 11'h000, off_ph_i = 11'h000;
    logic signed [15:0] amp_p = 16'sh0000, amp_n = 16'sh0000;
    logic smp_valid, half_tick, cycle_tick;
    logic signed [15:0] smp, lp, ln, hp, hn;
    logic [8:0] phase, on_ph_o, off_ph_o, rise_ph, fall_ph;
    logic [2:0] range_o;
    logic ev_o, trig_o, auto_o, disp_o, relay_o, err_o, relay_d = 1'b0;
    int bad_count = 0, total_checks = 0, cyc = 0;
    int ev_cnt = 0, trig_cnt = 0, on_ticks = 0;

    always #5 clk_i = ~clk_i;

    ipc_front_end i_ipc_front_end (.clk_i(clk_i), .relay_on_i(relay_o), .manual_on_i(manual_i),
        .amp_pos_i(amp_p), .amp_neg_i(amp_n), .smp_valid_o(smp_valid), .smp_o(smp),
        .half_tick_o(half_tick), .cycle_tick_o(cycle_tick), .phase_o(phase));

    ipc_inrush_capture i_ipc_inrush_capture (.clk_i(clk_i), .rst_n_i(rst_n_i),
        .mode_inrush_i(mode_i), .start_i(start_i), .smp_valid_i(smp_valid), .smp_i(smp),
        .half_tick_i(half_tick), .cycle_tick_i(cycle_tick), .phase_deg_i(phase),
        .trig_src_inrush_i(trig_src_i), .range_up_i(up_i), .range_down_i(down_i),
        .seq_enable_i(seq_en_i), .seq_cfg_we_i(cfg_we_i), .on_cycles_i(on_cyc_i),
        .off_cycles_i(off_cyc_i), .on_phase_i(on_ph_i), .off_phase_i(off_ph_i),
        .latest_pos_o(lp), .latest_neg_o(ln), .highest_pos_o(hp), .highest_neg_o(hn),
        .event_o(ev_o), .trig_o(trig_o), .range_o(range_o), .autorange_en_o(auto_o),
        .disp_inrush_o(disp_o), .relay_on_o(relay_o), .seq_err_o(err_o),
        .on_phase_o(on_ph_o), .off_phase_o(off_ph_o));

    // ----------------------------------------
    // helpers
    // ----------------------------------------
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        total_checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic conclude();
        $display("checks %0d mismatches %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    task automatic clks(input int n);
        repeat (n) @(negedge clk_i);
    endtask

    // n supply cycles of 360 clocks
    task automatic cycles(input int n);
        clks(n * 360);
    endtask

    task automatic peaks(input logic [15:0] a, b, c, d);
        check(lp, a);
        check(ln, b);
        check(hp, c);
        check(hn, d);
    endtask

    task automatic load(input logic [15:0] p, n);
        amp_p = p;
        amp_n = n;
        manual_i = 1'b1;
        cycles(2);
    endtask

    // ----------------------------------------
    // monitors and hang guard
    // ----------------------------------------
    always @(posedge clk_i) begin
        cyc++;
        if (ev_o === 1'b1) ev_cnt++;
        if (trig_o === 1'b1) trig_cnt++;
        if (relay_o === 1'b1 && cycle_tick === 1'b1) on_ticks++;
        if (relay_o === 1'b1 && relay_d === 1'b0) rise_ph = phase;
        if (relay_o === 1'b0 && relay_d === 1'b1) fall_ph = phase;
        relay_d = relay_o;
        if (cyc == 20000) begin
            bad_count++;
            conclude();
        end
    end

    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial begin
        clks(8);
        rst_n_i = 1'b1;
        clks(2);
        check(disp_o, 1'b0);
        check(auto_o, 1'b1);
        down_i = 1'b1;
        clks(1);
        down_i = 1'b0;
        check(range_o, 3'h4);
        // range steps, saturation at the top, re-entry restores top range
        mode_i = 1'b1;
        clks(2);
        check(disp_o, 1'b1);
        check(auto_o, 1'b0);
        for (int k = 0; k < 2; k++) begin
            down_i = 1'b1;
            clks(1);
            down_i = 1'b0;
            clks(1);
        end
        check(range_o, 3'h2);
        check(auto_o, 1'b0);
        up_i = 1'b1;
        clks(1);
        up_i = 1'b0;
        clks(1);
        check(range_o, 3'h3);
        mode_i = 1'b0;
        clks(2);
        mode_i = 1'b1;
        clks(2);
        check(range_o, 3'h4);
        up_i = 1'b1;
        clks(1);
        up_i = 1'b0;
        clks(1);
        check(range_o, 3'h4);
        // first transient, then larger and smaller steady peaks
        trig_src_i = 1'b1;
        load(16'h0064, 16'hFFB0);
        peaks(16'h0064, 16'hFFB0, 16'h0064, 16'hFFB0);
        check(ev_cnt, 16'h0001);
        check(trig_cnt, 16'h0001);
        load(16'h0096, 16'hFF88);
        load(16'h0032, 16'hFFD8);
        peaks(16'h0096, 16'hFF88, 16'h0096, 16'hFF88);
        check(ev_cnt, 16'h0001);
        // new switch-on with a smaller, negative-dominant transient
        trig_src_i = 1'b0;
        manual_i = 1'b0;
        cycles(2);
        load(16'h000A, 16'hFFC4);
        check(ev_cnt, 16'h0002);
        check(trig_cnt, 16'h0001);
        peaks(16'h000A, 16'hFFC4, 16'h0096, 16'hFF88);
        manual_i = 1'b0;
        clks(4);
        start_i = 1'b1;
        clks(1);
        start_i = 1'b0;
        clks(1);
        peaks(16'h0000, 16'h0000, 16'h0000, 16'h0000);
        // sequencer configuration: reject, then accept with wrapped phases
        on_cyc_i = 16'h0003;
        cfg_we_i = 1'b1;
        clks(1);
        cfg_we_i = 1'b0;
        clks(1);
        check(err_o, 1'b1);
        on_cyc_i = 16'h0004;
        off_cyc_i = 16'h0005;
        on_ph_i = 11'h419;
        off_ph_i = 11'h190;
        cfg_we_i = 1'b1;
        clks(1);
        cfg_we_i = 1'b0;
        clks(1);
        check(err_o, 1'b0);
        check(on_ph_o, 9'h051);
        check(off_ph_o, 9'h028);
        seq_en_i = 1'b1;
        cycles(7);
        check(rise_ph, 9'h052);
        check(fall_ph, 9'h029);
        check(on_ticks, 16'h0004);
        seq_en_i = 1'b0;
        clks(3);
        check(relay_o, 1'b0);
        conclude();
    end
endmodule // ipc_inrush_capture_tb
